// [logic/ttl_pkg.sv]
package ttl_pkg;
   // Clock period in ns, enable deadline in us
   localparam int CLK_PERIOD_NS = 25;
   localparam int ENABLE_MAX_US = 10;
   // Longest time rounds down
   localparam int ENABLE_CYCLES = (ENABLE_MAX_US * 1000) / CLK_PERIOD_NS;
   // Enable issued well inside the deadline
   localparam int ARM_CYCLES = 16;
   localparam logic [4:0] ARM_LAST = 5'h0F;
   localparam logic [4:0] ARM_ZERO = 5'h00;
   localparam logic [4:0] ARM_ONE = 5'h01;

   typedef enum logic [2:0] {
      TTL_OFF = 3'h1,
      TTL_ARMED = 3'h2,
      TTL_TRIPPED = 3'h4
   } ttl_state_t;
endpackage

// [logic/ttl_thermal_trip_latch.sv]
`timescale 1ns/100ps
module ttl_thermal_trip_latch (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic power_good_in,
   input wire logic trip_cond_in,
   output logic thermal_trip_n_out,
   output logic thermal_trip_n_oe,
   output logic core_clk_stop
);
   ttl_pkg::ttl_state_t state_reg;
   ttl_pkg::ttl_state_t state_next;
   logic [4:0] arm_cnt_reg;
   logic [4:0] arm_cnt_next;
   logic drive_reg;
   logic trip_reg;

   wire arm_done = (arm_cnt_reg == ttl_pkg::ARM_LAST);

   always_comb begin
      state_next = state_reg;
      arm_cnt_next = arm_cnt_reg;
      case (state_reg)
         ttl_pkg::TTL_OFF: begin
            arm_cnt_next = ttl_pkg::ARM_ZERO;
            if (power_good_in) begin
               state_next = ttl_pkg::TTL_ARMED;
            end
         end
         ttl_pkg::TTL_ARMED: begin
            if (!arm_done) begin
               arm_cnt_next = arm_cnt_reg + ttl_pkg::ARM_ONE;
            end
            if (trip_cond_in) begin
               state_next = ttl_pkg::TTL_TRIPPED;
            end
         end
         ttl_pkg::TTL_TRIPPED: begin
            if (!arm_done) begin
               arm_cnt_next = arm_cnt_reg + ttl_pkg::ARM_ONE;
            end
         end
         default: begin
            state_next = ttl_pkg::TTL_OFF;
         end
      endcase
      // Power good loss overrides everything
      if (!power_good_in) begin
         state_next = ttl_pkg::TTL_OFF;
         arm_cnt_next = ttl_pkg::ARM_ZERO;
      end
   end

   wire drive_next = power_good_in && (state_next != ttl_pkg::TTL_OFF) && (arm_cnt_next == ttl_pkg::ARM_LAST);
   wire trip_next = (state_next == ttl_pkg::TTL_TRIPPED);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ttl_pkg::TTL_OFF;
         arm_cnt_reg <= ttl_pkg::ARM_ZERO;
         drive_reg <= 1'h0;
         trip_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         arm_cnt_reg <= arm_cnt_next;
         drive_reg <= drive_next;
         trip_reg <= trip_next;
      end
   end

   // Open-drain: pull low when tripped and enabled
   assign thermal_trip_n_out = 1'h0;
   assign thermal_trip_n_oe = drive_reg && trip_reg;
   assign core_clk_stop = trip_reg;

   localparam int ENABLE_CYCLES = ttl_pkg::ENABLE_CYCLES;

   property p_enable_deadline;
      @(posedge clk) disable iff (!reset_n)
      $rose(power_good_in) |-> ##[1:ENABLE_CYCLES] (drive_reg || !power_good_in);
   endproperty
   a_enable_deadline: assert property (p_enable_deadline) else $error("drive not enabled in time");

   property p_drive_off;
      @(posedge clk) disable iff (!reset_n)
      !power_good_in |=> !thermal_trip_n_oe && !drive_reg;
   endproperty
   a_drive_off: assert property (p_drive_off) else $error("drive active without power good");

   property p_latched;
      @(posedge clk) disable iff (!reset_n)
      trip_reg && power_good_in |=> trip_reg;
   endproperty
   a_latched: assert property (p_latched) else $error("trip cleared while power good high");

   property p_clear;
      @(posedge clk) disable iff (!reset_n)
      !power_good_in |=> !trip_reg ##1 (!trip_reg || $past(trip_cond_in));
   endproperty
   a_clear: assert property (p_clear) else $error("trip not cleared or reasserted alone");

   property p_clk_stop;
      @(posedge clk) disable iff (!reset_n)
      $fell(core_clk_stop) |-> !$past(power_good_in);
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clocks restarted with power good high");

   sequence s_armed_hot;
      power_good_in && state_reg == ttl_pkg::TTL_ARMED && trip_cond_in;
   endsequence
   property p_set;
      @(posedge clk) disable iff (!reset_n)
      s_armed_hot ##1 power_good_in |-> trip_reg && core_clk_stop;
   endproperty
   a_set: assert property (p_set) else $error("trip not set on first high edge");

   property p_retrip;
      @(posedge clk) disable iff (!reset_n)
      ($rose(power_good_in) ##1 (power_good_in && trip_cond_in) [*2])
         |-> ##[0:ENABLE_CYCLES] (thermal_trip_n_oe || !power_good_in);
   endproperty
   a_retrip: assert property (p_retrip) else $error("no retrip while still hot");

   property p_oe_cause;
      @(posedge clk) disable iff (!reset_n)
      thermal_trip_n_oe |-> trip_reg && drive_reg && $past(power_good_in);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("output driven without cause");

   sequence s_pg_rise;
      $rose(power_good_in);
   endsequence
   sequence s_pg_held8;
      power_good_in [*8];
   endsequence

   property p_enable_exact;
      @(posedge clk) disable iff (!reset_n)
      s_pg_rise ##0 s_pg_held8 ##1 s_pg_held8 |=> drive_reg;
   endproperty
   a_enable_exact: assert property (p_enable_exact) else $error("drive not enabled after arming");

   property p_enable_not_early;
      @(posedge clk) disable iff (!reset_n)
      s_pg_rise ##0 s_pg_held8 ##1 power_good_in [*7] |=> !drive_reg;
   endproperty
   a_enable_not_early: assert property (p_enable_not_early) else $error("drive enabled early");

   property p_arm_zero;
      @(posedge clk) disable iff (!reset_n)
      state_reg == ttl_pkg::TTL_OFF |-> arm_cnt_reg == ttl_pkg::ARM_ZERO;
   endproperty
   a_arm_zero: assert property (p_arm_zero) else $error("arm count not idle");

   property p_arm_step;
      @(posedge clk) disable iff (!reset_n)
      (state_reg != ttl_pkg::TTL_OFF) && power_good_in && !arm_done
         |=> arm_cnt_reg == $past(arm_cnt_reg) + ttl_pkg::ARM_ONE;
   endproperty
   a_arm_step: assert property (p_arm_step) else $error("arm count did not advance");

   property p_cnt_hold;
      @(posedge clk) disable iff (!reset_n)
      (state_reg != ttl_pkg::TTL_OFF) && arm_done && power_good_in |=> arm_done;
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("arm count left its end");

   property p_drive_at_done;
      @(posedge clk) disable iff (!reset_n)
      (state_reg != ttl_pkg::TTL_OFF) && arm_done |-> drive_reg;
   endproperty
   a_drive_at_done: assert property (p_drive_at_done) else $error("drive off after arming");

   property p_drive_rise;
      @(posedge clk) disable iff (!reset_n)
      $rose(drive_reg) |-> arm_done && $past(power_good_in);
   endproperty
   a_drive_rise: assert property (p_drive_rise) else $error("drive enabled without arming");

   property p_drive_hold;
      @(posedge clk) disable iff (!reset_n)
      drive_reg && power_good_in |=> drive_reg;
   endproperty
   a_drive_hold: assert property (p_drive_hold) else $error("drive dropped with power good high");

   property p_pg_loss_state;
      @(posedge clk) disable iff (!reset_n)
      !power_good_in |=> state_reg == ttl_pkg::TTL_OFF && arm_cnt_reg == ttl_pkg::ARM_ZERO;
   endproperty
   a_pg_loss_state: assert property (p_pg_loss_state) else $error("state kept without power good");

   property p_off_no_trip;
      @(posedge clk) disable iff (!reset_n)
      state_reg == ttl_pkg::TTL_OFF |=> !trip_reg;
   endproperty
   a_off_no_trip: assert property (p_off_no_trip) else $error("trip set before arming");

   property p_trip_cause;
      @(posedge clk) disable iff (!reset_n)
      $rose(trip_reg) |-> $past(trip_cond_in) && $past(power_good_in);
   endproperty
   a_trip_cause: assert property (p_trip_cause) else $error("trip set without condition");

   property p_retrip_quick;
      @(posedge clk) disable iff (!reset_n)
      s_pg_rise ##1 (power_good_in && trip_cond_in) |=> trip_reg && core_clk_stop;
   endproperty
   a_retrip_quick: assert property (p_retrip_quick) else $error("no trip when hot after return");

   property p_cool_return;
      @(posedge clk) disable iff (!reset_n)
      s_pg_rise ##1 (power_good_in && !trip_cond_in) |=> !trip_reg;
   endproperty
   a_cool_return: assert property (p_cool_return) else $error("trip reasserted by power good alone");

   property p_state_onehot;
      @(posedge clk) disable iff (!reset_n)
      $onehot(state_reg);
   endproperty
   a_state_onehot: assert property (p_state_onehot) else $error("latch state not one-hot");
endmodule

// [sim/thermal_trip_latch_test.sv]
`timescale 1ns/100ps
module thermal_trip_latch_test;
   logic clk = 1'h0, reset_n = 1'h0, pg = 1'h0, cond = 1'h0;
   logic pin_out, oe, clk_stop, pwr_off;
   // Open-drain pin with board pull-up
   wire pin_n = oe ? pin_out : 1'h1;
   int err_total = 0, cmp_count = 0;
   ttl_thermal_trip_latch i_dut (.clk(clk), .reset_n(reset_n), .power_good_in(pg), .trip_cond_in(cond),
      .thermal_trip_n_out(pin_out), .thermal_trip_n_oe(oe), .core_clk_stop(clk_stop));
   ttl_board_model i_board (.clk(clk), .reset_n(reset_n), .trip_pin_n(pin_n), .core_power_off(pwr_off));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string what, input logic seen, input logic exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %b seen %b", what, exp, seen);
      end
   endtask
   task automatic set(input logic p, input logic c);
      @(posedge clk);
      pg <= p;
      cond <= c;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_pin(input int lim);
      int n;
      n = 0;
      while (pin_n !== 1'b0 && n < lim) begin
         cyc(1);
         n++;
      end
      chk("pin", pin_n, 1'h0);
   endtask
   task automatic test_done;
      $display("cmp_count %0d err_total %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic trip_latch;
      chk("pwr_on", pwr_off, 1'h0);
      set(1'h1, 1'h0);
      cyc(2);
      set(1'h1, 1'h1);
      cyc(3);
      chk("clk_stop", clk_stop, 1'h1);
      chk("oe_wait", oe, 1'h0);
      set(1'h1, 1'h0);
      wait_pin(ttl_pkg::ENABLE_CYCLES - 8);
      cyc(20);
      chk("latched", clk_stop, 1'h1);
      chk("pwr_off", pwr_off, 1'h1);
   endtask
   task automatic drop_return;
      set(1'h0, 1'h1);
      cyc(2);
      chk("oe", oe, 1'h0);
      chk("clear", clk_stop, 1'h0);
      set(1'h1, 1'h0);
      cyc(30);
      chk("no_retrip", clk_stop, 1'h0);
      set(1'h0, 1'h1);
      cyc(2);
      set(1'h1, 1'h1);
      wait_pin(ttl_pkg::ENABLE_CYCLES);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'h1;
      cyc(2);
      trip_latch();
      drop_return();
      test_done();
   end
   initial begin
      #100us;
      err_total++;
      test_done();
   end
endmodule

// [sim/ttl_board_model.sv]
`timescale 1ns/100ps
module ttl_board_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic trip_pin_n,
   output logic core_power_off
);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         core_power_off <= 1'h0;
      else if (!trip_pin_n)
         core_power_off <= 1'h1;
   end
endmodule
